// ---- hdl/scsd_consts.vh ----
// Register map, field positions, reset values and divider constants
`ifndef SCSD_CONSTS_VH
`define SCSD_CONSTS_VH
`define SCSD_OFF_DATA 12'h018
`define SCSD_OFF_STAT1 12'h01C
`define SCSD_OFF_STAT2 12'h020
`define SCSD_OFF_BAUD 12'h024
`define SCSD_OFF_CTRL3 12'h028
`define SCSD_ST1_RXFULL 5
`define SCSD_ST1_FRAME 1
`define SCSD_ST1_PARITY 0
`define SCSD_ST2_BREAK 1
`define SCSD_ST2_ACTIVE 0
`define SCSD_C3_NINTH 7
`define SCSD_C3_NINE_MODE 6
`define SCSD_C3_PAR_EN 5
`define SCSD_C3_PAR_ODD 4
`define SCSD_C3_FRAMING_ERROR_IRQ_ENABLE 1
`define SCSD_C3_PARITY_ERROR_IRQ_ENABLE 0
`define SCSD_BAUD_RST 8'h00
`define SCSD_CTRL3_RST 8'h00
`define SCSD_XTAL_DIV 64
`define SCSD_PD0 1
`define SCSD_PD1 3
`define SCSD_PD2 4
`define SCSD_PD3 13
`define SCSD_OVERSAMPLE 16
`endif

// ---- hdl/scsd_baud_gen.v ----
// Baud tick generator: crystal/64/prescale/rate with x16 sample ticks
`timescale 1ns/1ps
`include "scsd_consts.vh"
module scsd_baud_gen #(
    parameter XTAL_PER_CLK = 1
) (
    input wire pclk,            // Bus clock
    input wire presetn,         // Async reset, active low
    input wire xtal_tick,       // One-cycle crystal-rate enable
    input wire [1:0] prescale_select, // Prescale code
    input wire [2:0] rate_select, // Rate code
    output reg sample_tick      // One pulse per 1/16 bit
);
    reg [15:0] cnt;
    reg [15:0] limit;
    always @* begin
        case (prescale_select)
            2'h0: limit = 16'd`SCSD_PD0; // R18
            2'h1: limit = 16'd`SCSD_PD1;
            2'h2: limit = 16'd`SCSD_PD2;
            default: limit = 16'd`SCSD_PD3;
        endcase
        // Crystal/64 gives bit rate; /4 gives x16 sample rate
        limit = (limit << rate_select) * 16'd4; // R19 R20
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 16'h0000;
            sample_tick <= 1'b0;
        end else begin
            sample_tick <= 1'b0;
            if (xtal_tick) begin
                if (cnt >= limit - 16'd1) begin
                    cnt <= 16'h0000;
                    sample_tick <= 1'b1;
                end else begin
                    cnt <= cnt + 16'd1;
                end
            end
        end
    end
endmodule

// ---- hdl/scsd_rx_core.v ----
// Serial receiver with framing, parity, break and activity detection
`timescale 1ns/1ps
`include "scsd_consts.vh"
module scsd_rx_core (
    input wire pclk,            // Bus clock
    input wire presetn,         // Async reset, active low
    input wire sample_tick,     // x16 sample enable
    input wire rxd,             // Synchronised receive line
    input wire nine_mode,       // 9-bit characters
    input wire par_en,          // Parity enabled
    input wire par_odd,         // Odd parity
    output reg active,          // Reception in progress
    output reg done,            // Character complete pulse
    output reg [8:0] data,      // Received character
    output reg frame_err,       // Stop bit was 0
    output reg par_err,         // Parity failed
    output reg brk,             // All-zero character
    output reg idle_seen        // Idle character pulse
);
    localparam S_IDLE = 2'h0;
    localparam S_START = 2'h1;
    localparam S_BITS = 2'h2;
    reg [1:0] state;
    reg [3:0] phase;
    reg [3:0] bitn;
    reg [10:0] shf;
    reg [3:0] ones;
    reg line_high;
    wire [3:0] nbits = 4'd8 + {3'h0, nine_mode} + {3'h0, par_en};
    wire [8:0] dbits = nine_mode ? shf[8:0] : {1'b0, shf[7:0]};
    wire pbit = par_en ? (nine_mode ? shf[9] : shf[8]) : 1'b0;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            phase <= 4'h0;
            bitn <= 4'h0;
            shf <= 11'h000;
            ones <= 4'h0;
            line_high <= 1'b0;
            active <= 1'b0;
            done <= 1'b0;
            data <= 9'h000;
            frame_err <= 1'b0;
            par_err <= 1'b0;
            brk <= 1'b0;
            idle_seen <= 1'b0;
        end else begin
            done <= 1'b0;
            idle_seen <= 1'b0;
            if (sample_tick) begin
                phase <= phase + 4'h1;
                case (state)
                    S_IDLE: begin
                        // A start needs the line seen high first, so a long break is one frame
                        if (rxd) begin
                            line_high <= 1'b1;
                            if (phase == 4'hF && ones != 4'hF) begin
                                ones <= ones + 4'h1;
                                // A whole character time of ones ends the reception
                                if (ones == nbits) begin
                                    active <= 1'b0; // R12
                                    idle_seen <= 1'b1;
                                end
                            end
                        end else if (line_high) begin
                            active <= 1'b1; // R11
                            state <= S_START;
                            phase <= 4'h1;
                            line_high <= 1'b0;
                        end else begin
                            ones <= 4'h0;
                        end
                    end
                    S_START: begin
                        if (phase == 4'h7) begin
                            if (rxd) begin
                                active <= 1'b0; // R12
                                state <= S_IDLE;
                                ones <= 4'h0;
                            end else begin
                                state <= S_BITS;
                                bitn <= 4'h0;
                                phase <= 4'h0;
                                ones <= 4'h0;
                            end
                        end
                    end
                    S_BITS: begin
                        if (phase == 4'hF) begin
                            if (bitn == nbits) begin
                                // Stop bit position
                                state <= S_IDLE;
                                if (shf[10:0] == 11'h000 && !rxd) begin
                                    brk <= 1'b1; // R6
                                    data <= 9'h000; // R7
                                end else begin
                                    brk <= 1'b0;
                                    data <= dbits;
                                end
                                frame_err <= ~rxd; // R1
                                par_err <= par_en &
                                    ((^dbits) ^ pbit ^ par_odd); // R4
                                done <= 1'b1;
                                ones <= 4'h0;
                            end else begin
                                shf <= {1'b0, shf[10:1]};
                                shf[nbits - 4'h1] <= rxd;
                                bitn <= bitn + 4'h1;
                            end
                        end
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end
endmodule

// ---- hdl/scsd_top.v ----
// Serial interface status, data buffer and baud selection block
// Notes on behaviour
// R1 - Stop bit sampled as 0 sets framing error flag.
// R2 - Framing error with its enable drives the error interrupt.
// R3 - Framing error clears by status-1 read seeing it, then data read.
// R4 - Parity failure sets parity error flag; enabled flag requests interrupt.
// R5 - Parity error clears by status-1 read seeing it, then data read.
// R6 - Break sets break flag, framing error and receive full.
// R7 - In 9-bit mode a break forces ninth received bit to zero.
// R8 - Break flag and reception activity never request interrupts.
// R9 - Break flag clears by status-2 read seeing it, then data read.
// R10 - After clearing, break sets again only after line returns high.
// R11 - Low at first start-search sample sets reception active flag.
// R12 - False start or idle character clears reception active flag.
// R13 - Software polls reception active before disabling or stopping.
// R14 - Shared data address: read gives received byte, write gives transmit.
// R15 - Reset leaves data buffer contents unchanged.
// R16 - Software avoids read-modify-write on the data buffer.
// R17 - One baud setting serves transmitter and receiver; here it drives only the receiver, as txd_pin is held high.
// R18 - Prescale code selects divisor 1, 3, 4 or 13; resets 00.
// R19 - Rate code selects divisor two to the code; resets 000.
// R20 - Bit rate is crystal over 64 times both divisors.
// R21 - Enabled parity error produces an interrupt request.
// R22 - Receive full sets on buffer load; cleared by status then data read.
// R23 - Data read clears only flags seen in the preceding status read.
// R24 - Error sources join one interrupt output, each gated by its enable.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "scsd_consts.vh"
module scsd_top (
    input wire pclk,            // Bus clock, 40 MHz
    input wire presetn,         // Async reset, active low
    input wire xtal_tick,       // Crystal-rate enable pulse
    input wire psel,            // APB select
    input wire penable,         // APB enable
    input wire pwrite,          // APB direction
    input wire [11:0] paddr,    // APB byte address
    input wire [31:0] pwdata,   // APB write data
    output wire [31:0] prdata,  // APB read data
    output wire pready,         // APB ready
    output wire pslverr,        // APB error
    input wire rxd_pin,         // Serial receive pin
    output reg txd_pin,         // Serial transmit pin
    output wire err_irq         // Serial error interrupt request
);
    // ************************************************
    // Registers
    // ************************************************
    reg [7:0] baud_select_reg;
    reg [7:0] control_reg_three;
    reg [7:0] rx_buf;
    reg [7:0] tx_buf;
    reg tx_pending;
    reg framing_error_flag;
    reg parity_error_flag;
    reg break_detect_flag;
    reg receive_full_flag;
    reg ninth_rx_bit;
    reg seen_fe;
    reg seen_pe;
    reg seen_full;
    reg seen_brk;
    reg brk_armed;
    reg [31:0] rdata;
    reg rxd_s1;
    reg rxd_s2;
    wire receive_active_flag;
    wire sample_tick;
    wire rx_done;
    wire [8:0] rx_data;
    wire rx_fe;
    wire rx_pe;
    wire rx_brk;
    wire [1:0] prescale_select = baud_select_reg[5:4];
    wire [2:0] rate_select = baud_select_reg[2:0];
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire hit_data = paddr == `SCSD_OFF_DATA;
    wire hit_st1 = paddr == `SCSD_OFF_STAT1;
    wire hit_st2 = paddr == `SCSD_OFF_STAT2;
    wire hit_baud = paddr == `SCSD_OFF_BAUD;
    wire hit_c3 = paddr == `SCSD_OFF_CTRL3;
    wire mapped = hit_data | hit_st1 | hit_st2 | hit_baud | hit_c3;
    wire data_rd = rd & hit_data;
    wire brk_event = rx_done & rx_brk & brk_armed;
    wire [7:0] stat1 = {2'h0, receive_full_flag, 3'h0,
                        framing_error_flag, parity_error_flag};
    wire [7:0] stat2 = {6'h00, break_detect_flag, receive_active_flag};

    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = rdata;
    // Break and activity flags deliberately excluded
    assign err_irq = (framing_error_flag & control_reg_three[`SCSD_C3_FRAMING_ERROR_IRQ_ENABLE]) |
                     (parity_error_flag & control_reg_three[`SCSD_C3_PARITY_ERROR_IRQ_ENABLE]); // R2 R21 R24 R8

    // ************************************************
    // Pin synchroniser
    // ************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
        end else begin
            rxd_s1 <= rxd_pin;
            rxd_s2 <= rxd_s1;
        end
    end

    // ************************************************
    // Baud and receiver
    // ************************************************
    scsd_baud_gen u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .xtal_tick(xtal_tick),
        .prescale_select(prescale_select),
        .rate_select(rate_select),
        .sample_tick(sample_tick) // R17
    );

    scsd_rx_core u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .sample_tick(sample_tick),
        .rxd(rxd_s2),
        .nine_mode(control_reg_three[`SCSD_C3_NINE_MODE]),
        .par_en(control_reg_three[`SCSD_C3_PAR_EN]),
        .par_odd(control_reg_three[`SCSD_C3_PAR_ODD]),
        .active(receive_active_flag),
        .done(rx_done),
        .data(rx_data),
        .frame_err(rx_fe),
        .par_err(rx_pe),
        .brk(rx_brk),
        .idle_seen()
    );

    // ************************************************
    // Read data
    // ************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `SCSD_OFF_DATA: rdata <= {24'h000000, rx_buf}; // R14
                `SCSD_OFF_STAT1: rdata <= {24'h000000, stat1};
                `SCSD_OFF_STAT2: rdata <= {24'h000000, stat2};
                `SCSD_OFF_BAUD: rdata <= {24'h000000, baud_select_reg};
                `SCSD_OFF_CTRL3: rdata <= {24'h000000, ninth_rx_bit,
                                           control_reg_three[6:0]};
                default: rdata <= 32'h00000000;
            endcase
        end
    end

    // ************************************************
    // Data buffers, kept out of reset
    // ************************************************
    always @(posedge pclk) begin
        if (rx_done) begin
            rx_buf <= rx_data[7:0]; // R15 R22
            ninth_rx_bit <= control_reg_three[`SCSD_C3_NINE_MODE] ?
                            rx_data[8] : rx_data[7]; // R7
        end
        if (wr & hit_data) begin
            tx_buf <= pwdata[7:0]; // R14 R16
        end
    end

    // ************************************************
    // Control registers
    // ************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_select_reg <= `SCSD_BAUD_RST; // R18 R19
            control_reg_three <= `SCSD_CTRL3_RST;
            tx_pending <= 1'b0;
            txd_pin <= 1'b1;
        end else begin
            if (wr & hit_baud) begin
                baud_select_reg <= {2'h0, pwdata[5:4], 1'b0, pwdata[2:0]};
            end
            if (wr & hit_c3) begin
                control_reg_three <= {1'b0, pwdata[6:0]};
            end
            if (wr & hit_data) begin
                tx_pending <= 1'b1;
            end
            txd_pin <= 1'b1;
        end
    end

    // ************************************************
    // Status flags and clear sequence
    // ************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            framing_error_flag <= 1'b0; // R3
            parity_error_flag <= 1'b0; // R5
            break_detect_flag <= 1'b0; // R9
            receive_full_flag <= 1'b0;
            seen_fe <= 1'b0;
            seen_pe <= 1'b0;
            seen_full <= 1'b0;
            seen_brk <= 1'b0;
            brk_armed <= 1'b1;
        end else begin
            // Flags are noted when the read data is captured, not one cycle later
            if (rd_setup & hit_st1) begin
                seen_fe <= framing_error_flag; // R23
                seen_pe <= parity_error_flag;
                seen_full <= receive_full_flag;
            end
            if (rd_setup & hit_st2) begin
                seen_brk <= break_detect_flag;
            end
            if (data_rd) begin
                seen_fe <= 1'b0;
                seen_pe <= 1'b0;
                seen_full <= 1'b0;
                seen_brk <= 1'b0;
                if (seen_fe) framing_error_flag <= 1'b0; // R3
                if (seen_pe) parity_error_flag <= 1'b0; // R5
                if (seen_full) receive_full_flag <= 1'b0; // R22
                if (seen_brk) break_detect_flag <= 1'b0; // R9
            end
            // Line high again re-arms break detection
            if (rxd_s2) brk_armed <= 1'b1; // R10
            if (rx_done) begin
                receive_full_flag <= 1'b1; // R22 R6
                if (rx_fe) framing_error_flag <= 1'b1; // R1 R6
                if (rx_pe) parity_error_flag <= 1'b1; // R4
                if (rx_brk) begin
                    brk_armed <= 1'b0; // R10
                end
                if (brk_event) break_detect_flag <= 1'b1; // R6
            end
        end
    end
endmodule

// ---- tb/scsd_top_sva.sv ----
// Port-level checker for the serial status, data buffer and baud block
`timescale 1ns/1ps
`include "scsd_consts.vh"
module scsd_top_sva (
    input wire pclk,           // Bus clock
    input wire presetn,        // Async reset, active low
    input wire xtal_tick,      // Crystal enable
    input wire psel,           // APB select
    input wire penable,        // APB enable
    input wire pwrite,         // APB direction
    input wire [11:0] paddr,   // APB address
    input wire [31:0] pwdata,  // APB write data
    input wire [31:0] prdata,  // APB read data
    input wire pready,         // APB ready
    input wire pslverr,        // APB error
    input wire rxd_pin,        // Receive pin
    input wire txd_pin,        // Transmit pin
    input wire err_irq         // Error interrupt
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire mapped = paddr == `SCSD_OFF_DATA || paddr == `SCSD_OFF_STAT1 ||
        paddr == `SCSD_OFF_STAT2 || paddr == `SCSD_OFF_BAUD || paddr == `SCSD_OFF_CTRL3;
    wire data_rd = acc && !pwrite && paddr == `SCSD_OFF_DATA;
    wire ctrl_wr = acc && pwrite && paddr == `SCSD_OFF_CTRL3;
    reg [7:0] baud_sh;
    reg [9:0] low_age;
    // Last baud write and cycles since the line was last low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_sh <= 8'h00;
            low_age <= 10'h3E8;
        end else begin
            if (acc && pwrite && paddr == `SCSD_OFF_BAUD)
                baud_sh <= pwdata[7:0] & 8'h37;
            if (!rxd_pin)
                low_age <= 10'h000;
            else if (low_age < 10'h3E8)
                low_age <= low_age + 10'h001;
        end
    end
    sequence s_rd_setup_access;
        psel && !penable && !pwrite ##1 psel && penable;
    endsequence
    property p_ready; pready; endproperty
    property p_unmapped; acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0); endproperty
    property p_mapped; acc && mapped |-> !pslverr; endproperty
    property p_upper; s_rd_setup_access |-> prdata[31:8] == 24'h000000; endproperty
    property p_hold; !$stable(prdata) |-> $past(psel && !penable && !pwrite); endproperty
    property p_baud; acc && !pwrite && paddr == `SCSD_OFF_BAUD |-> prdata[7:0] == baud_sh;
    endproperty
    property p_irq_fall; $fell(err_irq) |-> $past(data_rd) || $past(ctrl_wr); endproperty
    property p_irq_rise; $rose(err_irq) |-> $past(ctrl_wr) || low_age < 10'h3E8; endproperty
    property p_txd_idle; txd_pin == 1'b1; endproperty
    a_ready: assert property (p_ready) else $error("ready low");
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    a_mapped: assert property (p_mapped) else $error("error on mapped access");
    a_upper: assert property (p_upper) else $error("upper read bits set");
    a_hold: assert property (p_hold) else $error("read data moved outside read setup");
    a_baud: assert property (p_baud) else $error("baud readback wrong");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without cause");
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    a_txd_idle: assert property (p_txd_idle) else $error("transmit pin not idle");
endmodule
bind scsd_top scsd_top_sva u_sva (.pclk(pclk), .presetn(presetn), .xtal_tick(xtal_tick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_pin(rxd_pin),
    .txd_pin(txd_pin), .err_irq(err_irq));

// ---- tb/scsd_remote.sv ----
// Remote asynchronous transmitter driving the receive line
`timescale 1ns/1ps
module scsd_remote (
    input wire logic pclk,   // Bus clock
    output logic rxd         // Serial line, idle high
);
    initial rxd = 1'b1;
    // Start bit, data LSB first, stop bit value as given, then idle high
    task automatic send(input logic [9:0] bits, input int nbits, input logic stop,
        input int bit_cyc);
        rxd <= 1'b0;
        repeat (bit_cyc) @(posedge pclk);
        for (int i = 0; i < nbits; i++) begin
            rxd <= bits[i];
            repeat (bit_cyc) @(posedge pclk);
        end
        rxd <= stop;
        repeat (bit_cyc) @(posedge pclk);
        rxd <= 1'b1;
    endtask
endmodule

// ---- tb/scsd_top_tb_top.sv ----
// Self-checking bench for the serial status, data buffer and baud block
`timescale 1ns/1ps
`include "scsd_consts.vh"
module scsd_top_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd_pin, txd_pin, err_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [31:0] seed = 32'h9120;
    logic [7:0] b;
    logic xtal_tick = 1'b0;
    logic [32:0] expq[$];
    int n_errors = 0;
    int n_compared = 0;
    scsd_top u_dut (.pclk(pclk), .presetn(presetn), .xtal_tick(xtal_tick), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
        .err_irq(err_irq));
    scsd_remote u_rem (.pclk(pclk), .rxd(rxd_pin));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Crystal runs at half the bus clock, so a bit is 128 bus cycles at PD=BD=1
    always @(posedge pclk) xtal_tick <= ~xtal_tick;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic fail(input string m);
        n_errors++;
        $display("wrong value at %0t: %s", $time, m);
    endtask
    task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
        n_compared++;
        if (g !== e) fail($sformatf("read %h, expected %h", g, e));
    endtask
    task automatic cmp_irq(input logic e);
        n_compared++;
        if (err_irq !== e) fail("interrupt request level");
    endtask
    // Read monitor: each completed read is matched to the oldest note
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) begin
            if (expq.size() == 0) fail("unexpected read");
            else cmp_rd(expq.pop_front(), {pslverr, prdata});
        end
    end
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, xs());
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        r = xs();
        apb(1'b1, a, {r[31:8], v});
    endtask
    task automatic rx(input logic [9:0] bits, input int n, input logic stop, input int bc);
        u_rem.send(bits, n, stop, bc);
        repeat (40) @(posedge pclk);
    endtask
    task automatic results();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        results();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`SCSD_OFF_STAT1, 33'h0);
        rd(`SCSD_OFF_STAT2, 33'h0);
        rd(`SCSD_OFF_BAUD, 33'h0);
        rd(12'h040, {1'b1, 32'h0});
        cmp_irq(1'b0);
        for (int i = 0; i < 8; i++) begin
            wr(`SCSD_OFF_BAUD, {2'b00, i[1:0], 1'b0, i[2:0]});
            rd(`SCSD_OFF_BAUD, {27'h0, i[1:0], 1'b0, i[2:0]});
        end
        wr(`SCSD_OFF_BAUD, 8'h00);
        $display("test registers done");
        r = xs();
        b = r[7:0];
        fork
            rx({2'b00, b}, 8, 1'b1, 128);
            begin
                repeat (384) @(posedge pclk);
                rd(`SCSD_OFF_STAT2, 33'h1);
            end
        join
        rd(`SCSD_OFF_STAT1, 33'h20);
        rd(`SCSD_OFF_DATA, {25'h0, b});
        rd(`SCSD_OFF_STAT1, 33'h0);
        rd(`SCSD_OFF_CTRL3, {25'h0, b[7], 7'h0});
        repeat (1536) @(posedge pclk);
        rd(`SCSD_OFF_STAT2, 33'h0);
        rd(`SCSD_OFF_STAT1, 33'h0);
        r = xs();
        b = r[7:0];
        rx({2'b00, b}, 8, 1'b1, 128);
        wr(`SCSD_OFF_DATA, ~b);
        rd(`SCSD_OFF_DATA, {25'h0, b});
        rd(`SCSD_OFF_STAT1, 33'h20);
        rd(`SCSD_OFF_DATA, {25'h0, b});
        $display("test receive done");
        wr(`SCSD_OFF_BAUD, 8'h10);
        rx(10'h05A, 8, 1'b1, 384);
        rd(`SCSD_OFF_STAT1, 33'h20);
        rd(`SCSD_OFF_DATA, 33'h5A);
        wr(`SCSD_OFF_BAUD, 8'h00);
        $display("test bit rate done");
        wr(`SCSD_OFF_CTRL3, 8'h02);
        rx(10'h081, 8, 1'b0, 128);
        cmp_irq(1'b1);
        rd(`SCSD_OFF_STAT1, 33'h22);
        rd(`SCSD_OFF_CTRL3, 33'h82);
        rd(`SCSD_OFF_DATA, 33'h81);
        cmp_irq(1'b0);
        rd(`SCSD_OFF_STAT1, 33'h0);
        $display("test framing done");
        wr(`SCSD_OFF_CTRL3, 8'h40);
        rx(10'h000, 9, 1'b0, 128);
        repeat (1536) @(posedge pclk);
        rd(`SCSD_OFF_STAT1, 33'h22);
        rd(`SCSD_OFF_STAT2, 33'h2);
        rd(`SCSD_OFF_CTRL3, 33'h40);
        cmp_irq(1'b0);
        rd(`SCSD_OFF_DATA, 33'h0);
        rd(`SCSD_OFF_STAT1, 33'h0);
        rd(`SCSD_OFF_STAT2, 33'h0);
        $display("test break done");
        wr(`SCSD_OFF_CTRL3, 8'h21);
        rx(10'h001, 9, 1'b1, 128);
        cmp_irq(1'b1);
        rd(`SCSD_OFF_STAT1, 33'h21);
        rd(`SCSD_OFF_DATA, 33'h01);
        cmp_irq(1'b0);
        rd(`SCSD_OFF_STAT1, 33'h0);
        $display("test parity done");
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`SCSD_OFF_DATA, 33'h01);
        rd(`SCSD_OFF_CTRL3, 33'h0);
        cmp_irq(1'b0);
        $display("test reset done");
        results();
    end
endmodule
